// File: adcsp_conv_model.sv
// converter core stand-in: answers each start pulse with one done pulse and data
// assumes start pulses never arrive while a conversion is still running
`timescale 1ns/10ps
module adcsp_conv_model #(
  parameter int CONV_CYCLES = 20
) (
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,
  input  wire logic [11:0] value_in,
  output logic             done_out,
  output logic      [11:0] data_out
);
  int   count;
  logic busy;
  // data line shows inverted value outside the done cycle, so stale data is never mistaken
  always @(posedge core_clk_in) begin
    done_out <= 1'b0;
    data_out <= ~value_in;
    if (srst_in) begin
      busy  <= 1'b0;
      count <= 0;
    end else if (busy) begin
      count <= count + 1;
      if (count == CONV_CYCLES - 1) begin
        busy     <= 1'b0;
        done_out <= 1'b1;
        data_out <= value_in;
      end
    end else if (start_in) begin
      busy  <= 1'b1;
      count <= 0;
    end
  end
endmodule

// File: adcsp_delay.sv
// one-shot delay counter: pulses done a fixed number of cycles after start
// assumes start is a one-cycle pulse in the core clock domain
`timescale 1ns/10ps
module adcsp_delay
  import adcsp_pkg::*;
#(
  parameter int CYCLES = ADCSP_ADVANCE_CYC
) (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic start_in,
  output logic      done_out
);
  initial begin
    if (CYCLES < 1 || CYCLES > 65535) begin
      $error("adcsp_delay: CYCLES out of range");
    end
  end

  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
    logic        done;
  } adcsp_dly_s;

  adcsp_dly_s st_reg;
  adcsp_dly_s st_next;

  // count down while running; a fresh start restarts the wait
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (start_in) begin
      st_next.run = 1'b1;
      st_next.cnt = 16'(CYCLES - 1);
    end else if (st_reg.run) begin
      if (st_reg.cnt == 16'h0000) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_out = st_reg.done;
endmodule

// File: adcsp_pkg.sv
// package for the converter scan register port: offsets, field positions, timing
// assumes a 125 MHz core clock and an 8-bit host data path with a 4-bit offset
package adcsp_pkg;
  localparam int        ADCSP_CLK_MHZ      = 125;
  localparam logic [3:0] ADCSP_OFF_RES_LO  = 4'h0;
  localparam logic [3:0] ADCSP_OFF_RES_HI  = 4'h1;
  localparam logic [3:0] ADCSP_OFF_SCAN    = 4'h2;
  localparam logic [3:0] ADCSP_OFF_STATUS  = 4'h8;
  localparam logic [3:0] ADCSP_OFF_CNT0    = 4'hC;
  localparam logic [3:0] ADCSP_OFF_CNT2    = 4'hE;
  localparam logic [3:0] ADCSP_OFF_CNTCTL  = 4'hF;
  localparam int        ADCSP_BUSY_BIT     = 7;
  localparam int        ADCSP_CFG_BIT      = 5;
  // channel advance delay after start, in ns (half a microsecond)
  localparam int        ADCSP_ADVANCE_NS   = 500;
  localparam int        ADCSP_ADVANCE_CYC  = (ADCSP_ADVANCE_NS * ADCSP_CLK_MHZ) / 1000;
  localparam logic [7:0] ADCSP_SCAN_RESET  = 8'h00;
  localparam logic [3:0] ADCSP_CHAN_RESET  = 4'h0;
endpackage

// File: adcsp_port.sv
// host register port of the 12-bit converter with its 16-input channel scanner
// assumes host strobes are one-cycle pulses synchronous to core_clk_in and that
// the converter core answers each start with one end-of-conversion pulse and data
`timescale 1ns/10ps
module adcsp_port
  import adcsp_pkg::*;
#(
  parameter int ADV_CYCLES = ADCSP_ADVANCE_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  input  wire logic [3:0] host_addr_in,
  input  wire logic [7:0] host_wdata_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  output logic      [7:0] host_rdata_out,
  input  wire logic       single_ended_in,
  input  wire logic       conv_done_in,
  input  wire logic [11:0] conv_data_in,
  output logic            conv_start_out,
  output logic      [3:0] channel_number_out,
  input  wire logic [7:0] cnt_rdata_in,
  output logic      [1:0] cnt_sel_out,
  output logic            cnt_load_out,
  output logic            cnt_ctl_wr_out,
  output logic      [7:0] cnt_wdata_out
);
  initial begin
    // upper bound keeps the advance inside the window that a_advance_time allows
    if (ADV_CYCLES < 1 || ADV_CYCLES > 299) begin
      $error("adcsp_port: ADV_CYCLES must lie in 1..299");
    end
  end

  typedef enum logic [0:0] {
    ADCSP_IDLE = 1'b0,
    ADCSP_CONV = 1'b1
  } adcsp_state_e;

  typedef struct packed {
    adcsp_state_e state;
    logic [3:0]   scan_start_channel;
    logic [3:0]   scan_stop_channel;
    logic [3:0]   channel_number;    // mux address of next conversion
    logic [3:0]   conv_channel;      // channel held by sample stage
    logic [3:0]   result_low_nibble;
    logic [7:0]   result_high_byte;
    logic [3:0]   latched_channel;
    logic         input_config_flag;
    logic         conv_start;
    logic [7:0]   rdata;
    logic [1:0]   cnt_sel;
    logic         cnt_load;
    logic         cnt_ctl_wr;
    logic [7:0]   cnt_wdata;
  } adcsp_port_s;

  adcsp_port_s st_reg;
  adcsp_port_s st_next;
  logic        advance_pulse;
  logic        wr_start;
  logic        wr_scan;

  // advance timer: fires once, half a microsecond after each start
  adcsp_delay #(
    .CYCLES (ADV_CYCLES)
  ) u_advance (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .start_in    (st_reg.conv_start),
    .done_out    (advance_pulse)
  );

  assign wr_start = host_wr_in && (host_addr_in == ADCSP_OFF_RES_LO);
  assign wr_scan  = host_wr_in && (host_addr_in == ADCSP_OFF_SCAN);

  // next-state logic; a start while busy is ignored so the busy window stays whole
  always_comb begin
    st_next            = st_reg;
    st_next.conv_start = 1'b0;
    st_next.cnt_load   = 1'b0;
    st_next.cnt_ctl_wr = 1'b0;
    st_next.input_config_flag = single_ended_in;
    if (wr_start && st_reg.state == ADCSP_IDLE) begin
      st_next.conv_start   = 1'b1;
      st_next.conv_channel = st_reg.channel_number;
      st_next.state        = ADCSP_CONV;   // busy set
    end
    if (advance_pulse) begin
      if (st_reg.channel_number == st_reg.scan_stop_channel) begin
        st_next.channel_number = st_reg.scan_start_channel;
      end else begin
        st_next.channel_number = st_reg.channel_number + 4'h1;
      end
    end
    if (conv_done_in && st_reg.state == ADCSP_CONV) begin
      st_next.state             = ADCSP_IDLE;
      st_next.result_low_nibble = conv_data_in[3:0];
      st_next.result_high_byte  = conv_data_in[11:4];
      st_next.latched_channel   = st_reg.conv_channel;
    end
    // scan limit write reloads address, wins over advance
    if (wr_scan) begin
      st_next.scan_stop_channel  = host_wdata_in[7:4];
      st_next.scan_start_channel = host_wdata_in[3:0];
      st_next.channel_number     = host_wdata_in[3:0];
    end
    if (host_wr_in && host_addr_in >= ADCSP_OFF_CNT0) begin
      st_next.cnt_wdata = host_wdata_in;
      if (host_addr_in == ADCSP_OFF_CNTCTL) begin
        st_next.cnt_ctl_wr = 1'b1;
      end else begin
        st_next.cnt_load = 1'b1;
        st_next.cnt_sel  = 2'(host_addr_in - ADCSP_OFF_CNT0);
      end
    end
    if (host_rd_in && host_addr_in >= ADCSP_OFF_CNT0 && host_addr_in <= ADCSP_OFF_CNT2) begin
      st_next.cnt_sel = 2'(host_addr_in - ADCSP_OFF_CNT0);
    end
    // read mux, answered the cycle after the strobe
    if (host_rd_in) begin
      case (host_addr_in)
        ADCSP_OFF_RES_LO: st_next.rdata = {st_reg.result_low_nibble, st_reg.latched_channel};
        ADCSP_OFF_RES_HI: st_next.rdata = st_reg.result_high_byte;
        ADCSP_OFF_SCAN:   st_next.rdata = {st_reg.scan_stop_channel, st_reg.scan_start_channel};
        ADCSP_OFF_STATUS: begin
          st_next.rdata                 = {4'h0, st_reg.channel_number};
          st_next.rdata[ADCSP_BUSY_BIT] = (st_reg.state == ADCSP_CONV);
          st_next.rdata[ADCSP_CFG_BIT]  = st_reg.input_config_flag;
        end
        4'hC, 4'hD, 4'hE: st_next.rdata = cnt_rdata_in;
        default:          st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg                    <= '0;
      st_reg.state              <= ADCSP_IDLE;
      st_reg.scan_stop_channel  <= ADCSP_SCAN_RESET[7:4];
      st_reg.scan_start_channel <= ADCSP_SCAN_RESET[3:0];
      st_reg.channel_number     <= ADCSP_CHAN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata_out     = st_reg.rdata;
  assign conv_start_out     = st_reg.conv_start;
  assign channel_number_out = st_reg.channel_number;
  assign cnt_sel_out        = st_reg.cnt_sel;
  assign cnt_load_out       = st_reg.cnt_load;
  assign cnt_ctl_wr_out     = st_reg.cnt_ctl_wr;
  assign cnt_wdata_out      = st_reg.cnt_wdata;

  a_start_sets_busy: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr_start && st_reg.state == ADCSP_IDLE) |=> (conv_start_out && st_reg.state == ADCSP_CONV))
    else $error("start did not set busy");
  a_busy_holds: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (st_reg.state == ADCSP_CONV && !conv_done_in) |=> st_reg.state == ADCSP_CONV)
    else $error("busy dropped before end");
  a_busy_no_restart: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr_start && st_reg.state == ADCSP_CONV) |=> !conv_start_out)
    else $error("start accepted while busy");
  a_latch_result: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (conv_done_in && st_reg.state == ADCSP_CONV)
      |=> st_reg.result_high_byte == $past(conv_data_in[11:4]))
    else $error("result not latched");
  a_result_holds: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !conv_done_in |=> $stable(st_reg.result_low_nibble) && $stable(st_reg.latched_channel))
    else $error("result changed without end");
  a_scan_reload: assert property (@(posedge core_clk_in) disable iff (srst_in)
    wr_scan |=> channel_number_out == $past(host_wdata_in[3:0]))
    else $error("scan write did not reload address");
  a_wrap_start: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (advance_pulse && !wr_scan && st_reg.channel_number == st_reg.scan_stop_channel)
      |=> channel_number_out == $past(st_reg.scan_start_channel))
    else $error("scanner did not wrap");
  a_advance_time: assert property (@(posedge core_clk_in) disable iff (srst_in)
    conv_start_out |-> ##[1:300] advance_pulse)
    else $error("channel did not advance in time");
  a_hi_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (host_rd_in && host_addr_in == ADCSP_OFF_RES_HI)
      |=> host_rdata_out == $past(st_reg.result_high_byte))
    else $error("high byte read wrong");
  a_status_busy: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (host_rd_in && host_addr_in == ADCSP_OFF_STATUS)
      |=> host_rdata_out[ADCSP_BUSY_BIT] == $past(st_reg.state == ADCSP_CONV))
    else $error("status busy bit wrong");
  // flag follows the pin through one register stage
  a_cfg_flag: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (host_rd_in && host_addr_in == ADCSP_OFF_STATUS && !$past(srst_in))
      |=> host_rdata_out[ADCSP_CFG_BIT] == $past(single_ended_in, 2))
    else $error("configuration flag wrong");
  a_unused_write: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (host_wr_in && host_addr_in == ADCSP_OFF_RES_HI && !advance_pulse)
      |=> $stable(channel_number_out))
    else $error("unused write changed state");
endmodule

// File: adcsp_port_tb.sv
// self-checking bench for the converter register port
// assumes the converter model answers every start and counters echo the offset
`timescale 1ns/10ps
module adcsp_port_tb
  import adcsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        se = 1'b1;
  logic [11:0] value = 12'h000;
  logic [7:0]  rdata, cnt_wdata, cnt_rdata, s;
  logic [11:0] conv_data;
  logic [3:0]  chan;
  logic [1:0]  cnt_sel;
  logic        done, start, cnt_load, cnt_ctl;
  int          checks = 0;
  int          miscompares = 0;
  // 125 MHz core clock
  always #4 clk = ~clk;
  // counter block echoes the offset so reads show which counter was picked
  assign cnt_rdata = {4'h5, addr};
  adcsp_port #(.ADV_CYCLES(2)) u_adcsp_port (
    .core_clk_in(clk), .srst_in(srst), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_wr_in(wr_s), .host_rd_in(rd_s), .host_rdata_out(rdata), .single_ended_in(se),
    .conv_done_in(done), .conv_data_in(conv_data), .conv_start_out(start),
    .channel_number_out(chan), .cnt_rdata_in(cnt_rdata), .cnt_sel_out(cnt_sel),
    .cnt_load_out(cnt_load), .cnt_ctl_wr_out(cnt_ctl), .cnt_wdata_out(cnt_wdata));
  adcsp_conv_model #(.CONV_CYCLES(20)) u_adcsp_conv_model (
    .core_clk_in(clk), .srst_in(srst), .start_in(start), .value_in(value),
    .done_out(done), .data_out(conv_data));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(posedge clk);
    #1 wr_s = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1 rd_s = 1'b0;
    d = rdata;
  endtask
  // start one conversion, see busy rise, then poll status until it drops
  task automatic convert(input logic [11:0] v);
    int n;
    value = v;
    wr(ADCSP_OFF_RES_LO, 8'hA5);
    check({7'h00, start}, 8'h01, "start pulse");
    rd(ADCSP_OFF_STATUS, s);
    check(s & 8'h80, 8'h80, "busy after start");
    // a second start while busy must not pulse the converter again
    wr(ADCSP_OFF_RES_LO, 8'h00);
    check({7'h00, start}, 8'h00, "start refused while busy");
    n = 0;
    do begin
      rd(ADCSP_OFF_STATUS, s);
      n++;
    end while (s[7] !== 1'b0 && n < 100);
    check(s & 8'h80, 8'h00, "busy clears");
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog well beyond the hundred and fifty or so cycles the tests take
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    rd(ADCSP_OFF_SCAN, s);
    check(s, 8'h00, "scan limits at reset");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h20, "status at reset");
    $display("test reset done");
    wr(ADCSP_OFF_SCAN, 8'h53);
    rd(ADCSP_OFF_SCAN, s);
    check(s, 8'h53, "scan limits readback");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h23, "address loads start");
    check({4'h0, chan}, 8'h03, "channel pin loads start");
    $display("test scan limits done");
    convert(12'hABC);
    rd(ADCSP_OFF_RES_LO, s);
    check(s, 8'hC3, "low nibble and channel");
    rd(ADCSP_OFF_RES_HI, s);
    check(s, 8'hAB, "high byte");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h24, "address advanced");
    convert(12'h123);
    rd(ADCSP_OFF_RES_LO, s);
    check(s, 8'h34, "second channel");
    convert(12'h456);
    rd(ADCSP_OFF_RES_LO, s);
    check(s, 8'h65, "stop channel");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h23, "wrap to start");
    $display("test scan cycle done");
    wr(ADCSP_OFF_RES_HI, 8'hFF);
    wr(4'hB, 8'hFF);
    rd(ADCSP_OFF_SCAN, s);
    check(s, 8'h53, "scan kept");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h23, "no conversion started");
    rd(ADCSP_OFF_RES_HI, s);
    check(s, 8'h45, "result held");
    $display("test unused offsets done");
    rd(ADCSP_OFF_CNT0, s);
    check(s, 8'h5C, "counter read");
    wr(4'hD, 8'h77);
    check({cnt_load, cnt_ctl, 4'h0, cnt_sel}, 8'h81, "counter load");
    check(cnt_wdata, 8'h77, "counter data");
    wr(ADCSP_OFF_CNTCTL, 8'h3C);
    check({cnt_load, cnt_ctl, 6'h00}, 8'h40, "counter control");
    check(cnt_wdata, 8'h3C, "control data");
    $display("test counters done");
    se = 1'b0;
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h03, "differential flag");
    $display("test config done");
    // differential inputs: start equals stop, top bits clear, start not above stop
    wr(ADCSP_OFF_SCAN, 8'h66);
    convert(12'h789);
    rd(ADCSP_OFF_RES_LO, s);
    check(s, 8'h96, "single channel result");
    rd(ADCSP_OFF_STATUS, s);
    check(s, 8'h06, "single channel repeats");
    $display("test single channel done");
    report_and_stop();
  end
endmodule
